// ===== adcc_top.sv
// Operation
// - restart discards partial result, begins afresh
// - input higher in comparator mode: flag stays
// - input higher raises no converter interrupt
// - comparison ends after two machine cycles plus clock
// - analog-selected pins lose their digital port function
// - result low bits go to working high bits
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module adcc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cmp_hi,
  output logic [adcc_pkg::RES_W-1:0] dac_code,
  output logic sample_en,
  output logic [adcc_pkg::CH_W-1:0] chan_sel,
  input wire logic [adcc_pkg::PINS-1:0] port_oe_req,
  input wire logic [adcc_pkg::PINS-1:0] port_out_req,
  input wire logic [adcc_pkg::PINS-1:0] pin_in,
  output logic [adcc_pkg::PINS-1:0] pin_oe,
  output logic [adcc_pkg::PINS-1:0] pin_out,
  output logic [adcc_pkg::PINS-1:0] port_in
);
  import adcc_pkg::*;

  adcc_conv_if cv ();

  logic mode_ff;
  logic [CH_W-1:0] ch_ff;
  logic ie_ff;
  logic done_flag_ff;
  logic skip_ff;
  logic high_ff;
  logic [WORK_W-1:0] work_ff;
  logic [RES_W-1:0] cmpv_ff;
  logic [IEV_W-1:0] istat_ff;
  logic [IEV_W-1:0] imask_ff;
  logic [PINS-1:0] pinsel_ff;
  logic start_ff;
  logic [1:0] div_ff;
  logic ck_en_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [PINS-1:0] pin_oe_ff;
  logic [PINS-1:0] pin_out_ff;
  logic [PINS-1:0] port_in_ff;
  logic [CH_W-1:0] chan_ff;

  logic wr_en;
  logic rd_setup;
  logic cmd_wr;
  logic mode_to_conv;
  logic done_set;
  logic skip_hit;
  logic [IEV_W-1:0] iev_set;
  logic [IEV_W-1:0] nxt_istat;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_CTRL, ADDR_INTC, ADDR_CMD, ADDR_STAT, ADDR_WORK, ADDR_RES,
      ADDR_CMPV, ADDR_ISTAT, ADDR_IMASK, ADDR_PINSEL: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] r);
    wr_hit = en && (a == r);
  endfunction

  // writes land on the access edge; reads are fetched in setup so the
  // slave can answer with no wait state
  assign wr_en = psel && penable && pwrite && pready_ff;
  assign rd_setup = psel && !penable;
  assign cmd_wr = wr_hit(wr_en, paddr, ADDR_CMD);
  assign mode_to_conv = wr_hit(wr_en, paddr, ADDR_CTRL) && mode_ff
    && !pwdata[CTRL_MODE_BIT];
  // the switch to converter mode itself raises the flag, as the converter input settles
  assign done_set = cv.done || mode_to_conv;
  assign skip_hit = cmd_wr && pwdata[CMD_SKIP_BIT] && done_flag_ff;
  // a done event or the switch to converter mode asks for the interrupt, gated by the enable
  assign iev_set[IEV_DONE_BIT] = done_set && ie_ff;
  assign iev_set[IEV_RESTART_BIT] = cmd_wr && pwdata[CMD_START_BIT] && cv.busy;
  assign nxt_istat = (wr_hit(wr_en, paddr, ADDR_ISTAT)
    ? (istat_ff & ~pwdata[IEV_W-1:0]) : istat_ff) | iev_set;

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= 1'b1;
      if (rd_setup) begin
        pslverr_ff <= !addr_mapped(paddr);
        prdata_ff <= 32'h0000_0000;
        case (paddr)
          ADDR_CTRL: begin
            prdata_ff[CTRL_MODE_BIT] <= mode_ff;
            prdata_ff[CTRL_CH_LSB +: CH_W] <= ch_ff;
          end
          ADDR_INTC: prdata_ff[INTC_IE_BIT] <= ie_ff;
          ADDR_STAT: begin
            prdata_ff[STAT_DONE_BIT] <= done_flag_ff;
            prdata_ff[STAT_BUSY_BIT] <= cv.busy;
            prdata_ff[STAT_SKIP_BIT] <= skip_ff;
            prdata_ff[STAT_HIGH_BIT] <= high_ff;
          end
          ADDR_WORK: prdata_ff[WORK_W-1:0] <= work_ff;
          ADDR_RES: prdata_ff[RES_W-1:0] <= cv.result;
          ADDR_CMPV: prdata_ff[RES_W-1:0] <= cmpv_ff;
          ADDR_ISTAT: prdata_ff[IEV_W-1:0] <= istat_ff;
          ADDR_IMASK: prdata_ff[IEV_W-1:0] <= imask_ff;
          ADDR_PINSEL: prdata_ff[PINS-1:0] <= pinsel_ff;
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= CTRL_MODE_RST;
      ch_ff <= CTRL_CH_RST;
      ie_ff <= INTC_IE_RST;
      cmpv_ff <= CMPV_RST;
      imask_ff <= IMASK_RST;
      pinsel_ff <= PINSEL_RST;
    end else begin
      // mode is taken as written; software keeps it still while busy
      if (wr_hit(wr_en, paddr, ADDR_CTRL)) begin
        mode_ff <= pwdata[CTRL_MODE_BIT];
        ch_ff <= pwdata[CTRL_CH_LSB +: CH_W];
      end
      if (wr_hit(wr_en, paddr, ADDR_INTC)) begin
        ie_ff <= pwdata[INTC_IE_BIT];
      end
      if (wr_hit(wr_en, paddr, ADDR_CMPV)) begin
        cmpv_ff <= pwdata[RES_W-1:0];
      end
      if (wr_hit(wr_en, paddr, ADDR_IMASK)) begin
        imask_ff <= pwdata[IEV_W-1:0];
      end
      if (wr_hit(wr_en, paddr, ADDR_PINSEL)) begin
        pinsel_ff <= pwdata[PINS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // instructions: start, skip on done flag, result low transfer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff <= 1'b0;
      done_flag_ff <= 1'b0;
      skip_ff <= 1'b0;
      high_ff <= 1'b0;
      work_ff <= WORK_RST;
    end else begin
      start_ff <= cmd_wr && pwdata[CMD_START_BIT];
      // a completion in the same cycle as the skip keeps the flag set
      if (done_set) begin
        done_flag_ff <= 1'b1;
      end else if (skip_hit) begin
        done_flag_ff <= 1'b0;
      end
      if (cmd_wr && pwdata[CMD_SKIP_BIT]) begin
        skip_ff <= done_flag_ff;
      end
      if (cv.high || cv.done) begin
        high_ff <= cv.high;
      end
      if (cmd_wr && pwdata[CMD_XFER_BIT]) begin
        work_ff <= {cv.result[1:0], 2'b00};
      end else if (wr_hit(wr_en, paddr, ADDR_WORK)) begin
        work_ff <= pwdata[WORK_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      irq_ff <= |(nxt_istat & imask_ff);
    end
  end

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
      ck_en_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff == 2'(CONV_CLK_DIV - 1)) ? 2'h0 : div_ff + 2'h1;
      ck_en_ff <= (div_ff == 2'(CONV_CLK_DIV - 1));
    end
  end

  // ----------------------------------------------------------------
  // shared pins: an analog pin is cut off from the digital port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_ff <= '0;
      pin_out_ff <= '0;
      port_in_ff <= '0;
      chan_ff <= '0;
    end else begin
      pin_oe_ff <= port_oe_req & ~pinsel_ff;
      pin_out_ff <= port_out_req & ~pinsel_ff;
      port_in_ff <= pin_in & ~pinsel_ff;
      chan_ff <= ch_ff;
    end
  end

  assign cv.start = start_ff;
  assign cv.mode = mode_ff;
  assign cv.ck_en = ck_en_ff;
  assign cv.cmp_val = cmpv_ff;

  adcc_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .cv(cv.sar),
    .cmp_hi(cmp_hi),
    .dac_ff(dac_code),
    .sample_ff(sample_en)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign chan_sel = chan_ff;
  assign pin_oe = pin_oe_ff;
  assign pin_out = pin_out_ff;
  assign port_in = port_in_ff;
endmodule

// ===== adcc_pkg.sv
package adcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INTC = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_WORK = 8'h10;
  localparam logic [7:0] ADDR_RES = 8'h14;
  localparam logic [7:0] ADDR_CMPV = 8'h18;
  localparam logic [7:0] ADDR_ISTAT = 8'h1C;
  localparam logic [7:0] ADDR_IMASK = 8'h20;
  localparam logic [7:0] ADDR_PINSEL = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_CH_LSB = 4;
  localparam int INTC_IE_BIT = 2;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_SKIP_BIT = 1;
  localparam int CMD_XFER_BIT = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_HIGH_BIT = 3;
  localparam int IEV_DONE_BIT = 0;
  localparam int IEV_RESTART_BIT = 1;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int RES_W = 10;
  localparam int WORK_W = 4;
  localparam int CH_W = 3;
  localparam int PINS = 8;
  localparam int IEV_W = 2;
  localparam int BIT_W = 4;
  localparam int CNT_W = 4;
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic [CH_W-1:0] CTRL_CH_RST = 3'h0;
  localparam logic INTC_IE_RST = 1'b0;
  localparam logic [WORK_W-1:0] WORK_RST = 4'h0;
  localparam logic [RES_W-1:0] CMPV_RST = 10'h000;
  localparam logic [IEV_W-1:0] IMASK_RST = 2'h0;
  localparam logic [PINS-1:0] PINSEL_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing, counted in pclk cycles
  // ----------------------------------------------------------------
  localparam int CONV_CLK_DIV = 4;
  localparam int MACH_CYC_CLKS = 3;
  localparam int CMP_MACH_CYCLES = 2;
  localparam int CMP_WAIT_CLKS = CMP_MACH_CYCLES * MACH_CYC_CLKS;
  localparam logic [BIT_W-1:0] MSB_IDX = 4'(RES_W - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CMP_MC = 3'b011,
    ST_CMP_CK = 3'b100
  } adcc_sar_st_t;

endpackage

// ===== adcc_conv_if.sv
`timescale 1ns/1ps
interface adcc_conv_if;
  import adcc_pkg::*;
  logic start;
  logic mode;
  logic ck_en;
  logic [RES_W-1:0] cmp_val;
  logic busy;
  logic done;
  logic high;
  logic [RES_W-1:0] result;

  modport ctl (output start, output mode, output ck_en, output cmp_val,
    input busy, input done, input high, input result);
  modport sar (input start, input mode, input ck_en, input cmp_val,
    output busy, output done, output high, output result);
endinterface

// ===== adcc_sar.sv
`timescale 1ns/1ps
module adcc_sar (
  input wire logic pclk,
  input wire logic presetn,
  adcc_conv_if.sar cv,
  input wire logic cmp_hi,
  output logic [adcc_pkg::RES_W-1:0] dac_ff,
  output logic sample_ff
);
  import adcc_pkg::*;

  adcc_sar_st_t st_ff;
  logic [BIT_W-1:0] bit_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [RES_W-1:0] trial;

  function automatic logic [RES_W-1:0] onehot(input logic [BIT_W-1:0] idx);
    onehot = RES_W'(1) << idx;
  endfunction

  // keep the trial bit only when the input stands above the dac level
  assign trial = cmp_hi ? dac_ff : (dac_ff & ~onehot(bit_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      bit_ff <= '0;
      cnt_ff <= '0;
      dac_ff <= '0;
      sample_ff <= 1'b0;
      cv.busy <= 1'b0;
      cv.done <= 1'b0;
      cv.high <= 1'b0;
      cv.result <= '0;
    end else begin
      cv.done <= 1'b0;
      cv.high <= 1'b0;
      if (cv.start) begin
        // a start always wins: partial result is dropped and the run restarts
        cv.result <= '0;
        cnt_ff <= '0;
        cv.busy <= 1'b1;
        if (cv.mode) begin
          st_ff <= ST_CMP_MC;
          dac_ff <= cv.cmp_val;
          sample_ff <= 1'b0;
        end else begin
          st_ff <= ST_SAMPLE;
          sample_ff <= 1'b1;
          bit_ff <= MSB_IDX;
          dac_ff <= onehot(MSB_IDX);
        end
      end else begin
        case (st_ff)
          ST_SAMPLE: begin
            if (cv.ck_en) begin
              st_ff <= ST_CONV;
              sample_ff <= 1'b0;
            end
          end
          ST_CONV: begin
            if (cv.ck_en) begin
              if (bit_ff == '0) begin
                st_ff <= ST_IDLE;
                cv.busy <= 1'b0;
                cv.done <= 1'b1;
                cv.result <= trial;
                dac_ff <= trial;
              end else begin
                bit_ff <= bit_ff - BIT_W'(1);
                dac_ff <= trial | onehot(bit_ff - BIT_W'(1));
              end
            end
          end
          ST_CMP_MC: begin
            // two machine cycles first, then the next conversion clock
            if (cnt_ff == CNT_W'(CMP_WAIT_CLKS - 1)) begin
              st_ff <= ST_CMP_CK;
            end else begin
              cnt_ff <= cnt_ff + CNT_W'(1);
            end
          end
          ST_CMP_CK: begin
            if (cv.ck_en) begin
              st_ff <= ST_IDLE;
              cv.busy <= 1'b0;
              cv.high <= cmp_hi;
              cv.done <= ~cmp_hi;
            end
          end
          default: begin
            st_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== adcc_chk.sv
`timescale 1ns/1ps
module adcc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [adcc_pkg::RES_W-1:0] dac_code,
  input wire logic sample_en,
  input wire logic [adcc_pkg::CH_W-1:0] chan_sel,
  input wire logic [adcc_pkg::PINS-1:0] port_oe_req,
  input wire logic [adcc_pkg::PINS-1:0] pin_oe
);
  import adcc_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  logic mode_ff;
  logic [CH_W-1:0] wch_ff;
  assign acc = psel && penable;
  assign bad = paddr > ADDR_PINSEL || paddr[1:0] != 2'h0;
  // shadow of the control word: mode is not visible at the ports, the channel shows only later at chan_sel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= CTRL_MODE_RST;
      wch_ff <= CTRL_CH_RST;
    end else if (acc && pwrite && paddr == ADDR_CTRL) begin
      mode_ff <= pwdata[CTRL_MODE_BIT];
      wch_ff <= pwdata[CTRL_CH_LSB +: CH_W];
    end
  end
  sequence s_ctrl_wr;
    acc && pwrite && paddr == ADDR_CTRL;
  endsequence
  sequence s_conv_go;
    acc && pwrite && paddr == ADDR_CMD && pwdata[CMD_START_BIT] && !mode_ff;
  endsequence
  sequence s_sample;
    sample_en && dac_code == 10'h200;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_READY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_ERR_BAD: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
  AST_ERR_OK: assert property (acc && !bad |-> !pslverr)
    else $error("error on mapped access");
  AST_CMD_RD0: assert property (acc && !pwrite && paddr == ADDR_CMD |-> prdata == 32'h0)
    else $error("command word reads nonzero");
  AST_START: assert property (s_conv_go |-> ##[1:4] s_sample)
    else $error("start did not begin a fresh sample");
  AST_SAMPLE_DAC: assert property ($rose(sample_en) |-> dac_code == 10'h200)
    else $error("sampling without midscale trial");
  AST_CHAN: assert property (s_ctrl_wr |-> ##2 chan_sel == wch_ff)
    else $error("channel select not updated");
  AST_PIN_OE: assert property ((pin_oe & ~$past(port_oe_req)) == '0)
    else $error("pin driven without request");
endmodule

bind adcc_top adcc_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dac_code(dac_code), .sample_en(sample_en),
  .chan_sel(chan_sel), .port_oe_req(port_oe_req), .pin_oe(pin_oe)
);

// ===== adcc_src_model.sv
`timescale 1ns/1ps
module adcc_src_model (
  input wire logic [adcc_pkg::RES_W-1:0] dac_code,
  input wire logic [adcc_pkg::CH_W-1:0] chan_sel,
  input wire logic [adcc_pkg::PINS*adcc_pkg::RES_W-1:0] vin,
  output logic cmp_hi
);
  import adcc_pkg::*;
  logic [RES_W:0] lvl;
  // each source sits half a code above its value, so no trial lands on the trip point
  assign lvl = {vin[chan_sel*RES_W +: RES_W], 1'b1};
  assign cmp_hi = lvl > {dac_code, 1'b0};
endmodule

// ===== adcc_top_tb.sv
`timescale 1ns/1ps
module adcc_top_tb;
  import adcc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk, presetn, psel, penable, pwrite, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, irq, cmp_hi, sample_en;
  logic [RES_W-1:0] dac_code;
  logic [CH_W-1:0] chan_sel;
  logic [PINS-1:0] port_oe_req, port_out_req, pin_in, pin_oe, pin_out, port_in, ext_pin;
  logic [PINS*RES_W-1:0] vin;
  int error_cnt = 0;
  int compares = 0;

  adcc_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cmp_hi(cmp_hi), .dac_code(dac_code), .sample_en(sample_en),
    .chan_sel(chan_sel), .port_oe_req(port_oe_req), .port_out_req(port_out_req),
    .pin_in(pin_in), .pin_oe(pin_oe), .pin_out(pin_out), .port_in(port_in)
  );
  adcc_src_model u_src (.dac_code(dac_code), .chan_sel(chan_sel), .vin(vin), .cmp_hi(cmp_hi));
  // a pin the block drives shows its own level, otherwise the outside one
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);

  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    // a slave that never answers counts as a mismatch, the bench runs on
    if (pready !== 1'b1) begin
      chk("pready", 32'(pready), 32'h1);
    end
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q & m, e);
  endtask
  task wait_done();
    int n;
    n = 0;
    q = 32'h0;
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 40) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      n++;
    end
    chk("done wait", 32'(q[STAT_DONE_BIT]), 32'h1);
  endtask
  task finish_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    for (int i = 0; i < 10; i++) begin
      rm(8'(4 * i), ALL, 32'h0);
    end
    rm(8'h28, ALL, 32'h0);
    chk("unmapped pslverr", 32'(serr), 32'h1);
  endtask
  task t_conv();
    vin[2*RES_W +: RES_W] <= 10'h2B7;
    apb(1'b1, ADDR_CTRL, 32'h20);
    apb(1'b1, ADDR_INTC, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h1);
    wait_done();
    rm(ADDR_RES, ALL, 32'h2B7);
    rm(ADDR_STAT, ALL, 32'h1);
    rm(ADDR_ISTAT, ALL, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, ADDR_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, ADDR_CMD, 32'h2);
    rm(ADDR_STAT, ALL, 32'h4);
    apb(1'b1, ADDR_ISTAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b1, ADDR_WORK, 32'hF);
    apb(1'b1, ADDR_CMD, 32'h4);
    rm(ADDR_WORK, ALL, 32'hC);
  endtask
  task t_restart();
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (12) @(posedge pclk);
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (30) @(posedge pclk);
    // the skip result of the earlier skip command still stands
    rm(ADDR_STAT, ALL, 32'h6);
    rm(ADDR_RES, ALL, 32'h0);
    rm(ADDR_ISTAT, ALL, 32'h2);
    wait_done();
    rm(ADDR_RES, ALL, 32'h2B7);
    apb(1'b1, ADDR_ISTAT, 32'h3);
    apb(1'b1, ADDR_CMD, 32'h2);
  endtask
  task cmp_run(input logic [RES_W-1:0] v, input logic [31:0] es, input logic [31:0] ei);
    vin[RES_W +: RES_W] <= v;
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    // skip result stays set from the last skip with the flag up
    rm(ADDR_STAT, ALL, 32'h6);
    repeat (8) @(posedge pclk);
    rm(ADDR_STAT, ALL, es);
    rm(ADDR_ISTAT, ALL, ei);
    chk("irq compare", 32'(irq), ei);
  endtask
  task t_cmp();
    apb(1'b1, ADDR_CMPV, 32'h100);
    apb(1'b1, ADDR_CTRL, 32'h18);
    cmp_run(10'h050, 32'h5, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h2);
    apb(1'b1, ADDR_ISTAT, 32'h1);
    cmp_run(10'h300, 32'hC, 32'h0);
  endtask
  task t_mode();
    apb(1'b1, ADDR_INTC, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h10);
    rm(ADDR_STAT, 32'h1, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h2);
    rm(ADDR_STAT, 32'h7, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h2);
    rm(ADDR_STAT, 32'h5, 32'h0);
  endtask
  task t_pins();
    apb(1'b1, ADDR_PINSEL, 32'hF0);
    port_oe_req <= 8'hFF;
    port_out_req <= 8'hA5;
    ext_pin <= 8'h3C;
    repeat (4) @(posedge pclk);
    chk("pin_oe", 32'(pin_oe), 32'h0F);
    chk("pin_out", 32'(pin_out), 32'h05);
    chk("port_in", 32'(port_in), 32'h05);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_oe_req = 8'h00;
    port_out_req = 8'h00;
    ext_pin = 8'h00;
    vin = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_conv();
    t_restart();
    t_cmp();
    t_mode();
    t_pins();
    finish_test();
  end
endmodule
